// file: hw/snc_pkg.sv
// Constants and types shared by the SPI nvSRAM command and status block.
// Assumes a single 100 MHz system clock; SPI pins are asynchronous to it.
// Notes on behaviour
// - Each opcode is shifted into an 8-bit register and decoded before later bytes.
// - All bytes travel MSB first; every transaction starts on chip select falling.
// - 0x05 reads status, 0x09 reads status fast, 0x01 writes status.
// - 0x06 sets the write-enable latch, 0x04 clears it.
// - 0x03 array read, 0x0B fast array read, 0x02 array write.
// - 0x3C save, 0x60 restore, 0x59 autosave on, 0x19 autosave off.
// - 0xC2 serial id write, 0xC3 serial id read, 0xC9 fast serial id read.
// - 0x9F ident read, 0x99 fast ident read, 0xB9 enters sleep.
// - Exactly 18 instructions; 0x1E is reserved and treated as undefined.
// - Fast status read takes one dummy byte before status is output.
// - Status: pin enable 7, lock 6, unused 5:4, protect level 3:2, latch 1, busy 0.
// - Busy bit is read-only and reads 1 while save or restore runs.
// - Latch bit reads 1 when writes enabled and is 0 after power-up.
// - Status write changes pin enable, lock and protect level; latch and busy untouched.
// - Bits 5 and 4 ignore writes and always read 0.
// - Lock bit, once 1, locks the serial id and never returns to 0.
// - Latch, protect level, bits 5:4, lock and pin enable all start at 0.
// - Pin enable gates the external write-protect pin; clear means pin ignored.
// - Undefined opcode: ignore all input until next chip select fall, output high-z.
// - One opcode per chip select low period.
// - Clock level at chip select fall selects mode 0 (low) or mode 3 (high).
// - After any write-type or nonvolatile instruction the latch is cleared, except a status write blocked by the protect pin or a locked serial id write.
package snc_pkg;
    localparam logic [7:0] OP_STATUS_READ      = 8'h05;
    localparam logic [7:0] OP_FAST_STATUS_READ = 8'h09;
    localparam logic [7:0] OP_STATUS_WRITE     = 8'h01;
    localparam logic [7:0] OP_LATCH_SET        = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR      = 8'h04;
    localparam logic [7:0] OP_ARRAY_READ       = 8'h03;
    localparam logic [7:0] OP_FAST_ARRAY_READ  = 8'h0B;
    localparam logic [7:0] OP_ARRAY_WRITE      = 8'h02;
    localparam logic [7:0] OP_NV_SAVE          = 8'h3C;
    localparam logic [7:0] OP_NV_RESTORE       = 8'h60;
    localparam logic [7:0] OP_AUTOSAVE_EN      = 8'h59;
    localparam logic [7:0] OP_AUTOSAVE_DIS     = 8'h19;
    localparam logic [7:0] OP_SLEEP            = 8'hB9;
    localparam logic [7:0] OP_SERIAL_WRITE     = 8'hC2;
    localparam logic [7:0] OP_SERIAL_READ      = 8'hC3;
    localparam logic [7:0] OP_FAST_SERIAL_READ = 8'hC9;
    localparam logic [7:0] OP_IDENT_READ       = 8'h9F;
    localparam logic [7:0] OP_FAST_IDENT_READ  = 8'h99;
    localparam logic [7:0] OP_RESERVED         = 8'h1E;
    localparam int         ST_BUSY_BIT         = 0;
    localparam int         ST_LATCH_BIT        = 1;
    localparam int         ST_LEVEL_LO_BIT     = 2;
    localparam int         ST_LEVEL_HI_BIT     = 3;
    localparam int         ST_LOCK_BIT         = 6;
    localparam int         ST_PIN_EN_BIT       = 7;
    localparam logic [7:0] ST_RESET            = 8'h00;
    localparam logic [2:0] LAST_BIT            = 3'h7;
    localparam int         SYNC_WIDTH          = 5;

    typedef enum logic [4:0] {
        cmd_none,
        status_read_cmd,
        fast_status_read_cmd,
        status_write_cmd,
        write_latch_set_cmd,
        write_latch_clear_cmd,
        array_read_cmd,
        fast_array_read_cmd,
        array_write_cmd,
        nv_save_cmd,
        nv_restore_cmd,
        autosave_enable_cmd,
        autosave_disable_cmd,
        sleep_cmd,
        serial_id_write_cmd,
        serial_id_read_cmd,
        fast_serial_id_read_cmd,
        ident_read_cmd,
        fast_ident_read_cmd
    } snc_cmd_type;

    typedef enum logic [2:0] {
        st_idle,
        st_opcode,
        st_dummy,
        st_send,
        st_status_write,
        st_pass,
        st_ignore
    } snc_fsm_type;
endpackage

// file: hw/snc_dec_if.sv
// Carries the captured opcode to the decoder and its verdict back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
interface snc_dec_if;
    import snc_pkg::*;
    logic [7:0]  opcode;
    snc_cmd_type cmd;
    logic        needs_latch;
    modport host (output opcode, input cmd, input needs_latch);
    modport dec  (input opcode, output cmd, output needs_latch);
endinterface
`default_nettype wire

// file: hw/snc_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins change slowly against clk_i.
`timescale 1ns/100ps
`default_nettype none
module snc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } snc_sync_type;

    snc_sync_type s;
    snc_sync_type next_s;

    // First stage feeds only the second
    always_comb begin
        next_s.meta = d_i;
        next_s.q    = s.meta;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.q;
endmodule
`default_nettype wire

// file: hw/snc_decode.sv
// Opcode classifier: maps the captured byte to one instruction class.
// Assumes the opcode is stable whenever the host looks at the result.
`timescale 1ns/100ps
`default_nettype none
module snc_decode
    import snc_pkg::*;
(
    snc_dec_if.dec dif
);
    always_comb begin
        dif.needs_latch = 1'b0;
        unique case (dif.opcode)
            OP_STATUS_READ:      dif.cmd = status_read_cmd;
            OP_FAST_STATUS_READ: dif.cmd = fast_status_read_cmd;
            OP_STATUS_WRITE:     dif.cmd = status_write_cmd;
            OP_LATCH_SET:        dif.cmd = write_latch_set_cmd;
            OP_LATCH_CLEAR:      dif.cmd = write_latch_clear_cmd;
            OP_ARRAY_READ:       dif.cmd = array_read_cmd;
            OP_FAST_ARRAY_READ:  dif.cmd = fast_array_read_cmd;
            OP_ARRAY_WRITE:      dif.cmd = array_write_cmd;
            OP_NV_SAVE:          dif.cmd = nv_save_cmd;
            OP_NV_RESTORE:       dif.cmd = nv_restore_cmd;
            OP_AUTOSAVE_EN:      dif.cmd = autosave_enable_cmd;
            OP_AUTOSAVE_DIS:     dif.cmd = autosave_disable_cmd;
            OP_SERIAL_WRITE:     dif.cmd = serial_id_write_cmd;
            OP_SERIAL_READ:      dif.cmd = serial_id_read_cmd;
            OP_FAST_SERIAL_READ: dif.cmd = fast_serial_id_read_cmd;
            OP_IDENT_READ:       dif.cmd = ident_read_cmd;
            OP_FAST_IDENT_READ:  dif.cmd = fast_ident_read_cmd;
            OP_SLEEP:            dif.cmd = sleep_cmd;
            // Reserved code falls here with every other undefined byte
            default:             dif.cmd = cmd_none;
        endcase
        // Write-type and nonvolatile instructions need the latch
        unique case (dif.cmd)
            status_write_cmd, array_write_cmd, serial_id_write_cmd,
            nv_save_cmd, nv_restore_cmd,
            autosave_enable_cmd, autosave_disable_cmd: dif.needs_latch = 1'b1;
            default:                                   dif.needs_latch = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// file: hw/snc_top.sv
// SPI slave command decoder and status register of the nvSRAM.
// Assumes SPI pins are asynchronous and far slower than clk_i;
// array, serial id and save logic sit outside and follow cmd_valid_o.
`timescale 1ns/100ps
`default_nettype none
module snc_top
    import snc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    input  wire logic        wp_n_i,
    input  wire logic        hw_save_busy_n_i,
    input  wire logic        nv_busy_i,
    output logic             so_o,
    output logic             so_oe_n_o,
    output logic             cmd_valid_o,
    output var snc_cmd_type  cmd_o,
    output logic [7:0]       status_o,
    output logic             spi_mode3_o,
    output logic             wp_pin_gate_o
);
    typedef struct packed {
        snc_fsm_type fsm;
        logic        cs_q;
        logic        sck_q;
        logic        mode3;
        logic [7:0]  rx;
        logic [2:0]  rx_cnt;
        logic [7:0]  tx;
        logic [2:0]  tx_cnt;
        snc_cmd_type cmd;
        logic        cmd_valid;
        logic        latch;
        logic        level_hi;
        logic        level_lo;
        logic        lock;
        logic        pin_en;
        logic        busy;
        logic        wp_block;
        logic        set_pend;
        logic        clr_pend;
        logic        so;
        logic        so_oe_n;
        logic        pin_gate;
    } snc_reg_type;

    localparam snc_reg_type REG_RESET = '{
        fsm:      st_idle,
        cs_q:     1'b1,
        cmd:      cmd_none,
        so_oe_n:  1'b1,
        level_hi: ST_RESET[ST_LEVEL_HI_BIT],
        level_lo: ST_RESET[ST_LEVEL_LO_BIT],
        lock:     ST_RESET[ST_LOCK_BIT],
        pin_en:   ST_RESET[ST_PIN_EN_BIT],
        latch:    ST_RESET[ST_LATCH_BIT],
        default:  '0
    };

    snc_reg_type s;
    snc_reg_type next_s;

    logic [SYNC_WIDTH-1:0] pins_sync;
    logic                  cs_sel_s;
    logic                  hsb_s;
    logic                  cs_n_s;
    logic                  sck_s;
    logic                  si_s;
    logic                  wp_n_s;
    logic                  hsb_n_s;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cs_fall;
    logic                  cs_rise;
    logic                  selected;
    logic                  op_done;
    logic [7:0]            rx_byte;
    logic [7:0]            cur_status;

    snc_dec_if dif ();

    // Every pin except nv_busy_i passes two flops before use
    snc_sync #(
        .W (SYNC_WIDTH)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        // Chip select and save-busy pins enter inverted so the flops' reset zero reads as idle
        .d_i      ({~cs_n_i, sck_i, si_i, wp_n_i, ~hw_save_busy_n_i}),
        .q_o      (pins_sync)
    );

    snc_decode u_decode (
        .dif (dif.dec)
    );

    assign {cs_sel_s, sck_s, si_s, wp_n_s, hsb_s} = pins_sync;
    // No false chip select fall or busy blip right after reset
    assign cs_n_s   = ~cs_sel_s;
    assign hsb_n_s  = ~hsb_s;
    assign sck_rise = sck_s & ~s.sck_q;
    assign sck_fall = ~sck_s & s.sck_q;
    assign cs_fall  = ~cs_n_s & s.cs_q;
    assign cs_rise  = cs_n_s & ~s.cs_q;
    assign selected = ~cs_n_s & ~s.cs_q;
    assign rx_byte  = {s.rx[6:0], si_s};
    assign op_done  = selected & sck_rise & (s.fsm == st_opcode) & (s.rx_cnt == LAST_BIT);
    assign dif.opcode = rx_byte;

    // Unused bits are constant zero, never stored
    always_comb begin
        cur_status                  = ST_RESET;
        cur_status[ST_PIN_EN_BIT]   = s.pin_en;
        cur_status[ST_LOCK_BIT]     = s.lock;
        cur_status[ST_LEVEL_HI_BIT] = s.level_hi;
        cur_status[ST_LEVEL_LO_BIT] = s.level_lo;
        cur_status[ST_LATCH_BIT]    = s.latch;
        cur_status[ST_BUSY_BIT]     = s.busy;
    end

    always_comb begin
        next_s           = s;
        next_s.cmd_valid = 1'b0;
        next_s.cs_q      = cs_n_s;
        next_s.sck_q     = sck_s;
        // Busy is read-only and tracks save/restore from either source
        next_s.busy      = nv_busy_i | ~hsb_n_s;
        next_s.pin_gate  = s.pin_en & ~wp_n_s;
        if (cs_n_s) begin
            // Latch changes commit when the frame closes
            if (cs_rise && s.clr_pend) begin
                next_s.latch = 1'b0;
            end
            if (cs_rise && s.set_pend) begin
                next_s.latch = 1'b1;
            end
            next_s.fsm      = st_idle;
            next_s.so_oe_n  = 1'b1;
            next_s.set_pend = 1'b0;
            next_s.clr_pend = 1'b0;
        end else if (cs_fall) begin
            // Fresh frame: the first byte is always an opcode
            next_s.fsm    = st_opcode;
            next_s.mode3  = sck_s;
            next_s.rx_cnt = 3'h0;
            next_s.tx_cnt = 3'h0;
        end else begin
            if (sck_rise) begin
                next_s.rx     = rx_byte;
                next_s.rx_cnt = s.rx_cnt + 3'h1;
            end
            if (op_done) begin
                // Protection state is frozen at decode; later pin moves are ignored
                next_s.wp_block = s.pin_en & ~wp_n_s;
                if (dif.cmd == cmd_none) begin
                    next_s.fsm = st_ignore;
                end else if (dif.needs_latch && !s.latch) begin
                    next_s.fsm = st_ignore;
                end else if (dif.cmd == serial_id_write_cmd && s.lock) begin
                    next_s.fsm = st_ignore;
                end else begin
                    next_s.cmd_valid = 1'b1;
                    next_s.cmd       = dif.cmd;
                    next_s.set_pend  = (dif.cmd == write_latch_set_cmd);
                    next_s.clr_pend  = dif.needs_latch |
                                       (dif.cmd == write_latch_clear_cmd);
                    if (dif.cmd == status_read_cmd) begin
                        next_s.fsm = st_send;
                    end else if (dif.cmd == fast_status_read_cmd) begin
                        next_s.fsm = st_dummy;
                    end else if (dif.cmd == status_write_cmd) begin
                        next_s.fsm = st_status_write;
                    end else begin
                        // Data path for other commands lives outside
                        next_s.fsm = st_pass;
                    end
                end
            end else if (sck_rise && s.rx_cnt == LAST_BIT) begin
                if (s.fsm == st_dummy) begin
                    next_s.fsm = st_send;
                end
                if (s.fsm == st_status_write) begin
                    next_s.fsm = st_pass;
                    if (s.wp_block) begin
                        // Blocked write leaves the latch armed
                        next_s.clr_pend = 1'b0;
                    end else begin
                        next_s.pin_en   = rx_byte[ST_PIN_EN_BIT];
                        next_s.level_hi = rx_byte[ST_LEVEL_HI_BIT];
                        next_s.level_lo = rx_byte[ST_LEVEL_LO_BIT];
                        next_s.lock     = s.lock | rx_byte[ST_LOCK_BIT];
                    end
                end
            end
            // Status repeats while the master keeps clocking
            if (sck_fall && s.fsm == st_send) begin
                next_s.so_oe_n = 1'b0;
                next_s.tx_cnt  = s.tx_cnt + 3'h1;
                if (s.tx_cnt == 3'h0) begin
                    next_s.so = cur_status[7];
                    next_s.tx = {cur_status[6:0], 1'b0};
                end else begin
                    next_s.so = s.tx[7];
                    next_s.tx = {s.tx[6:0], 1'b0};
                end
            end
            if (s.fsm == st_ignore) begin
                next_s.so_oe_n = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= REG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign so_o          = s.so;
    assign so_oe_n_o     = s.so_oe_n;
    assign cmd_valid_o   = s.cmd_valid;
    assign cmd_o         = s.cmd;
    assign status_o      = cur_status;
    assign spi_mode3_o   = s.mode3;
    assign wp_pin_gate_o = s.pin_gate;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence seq_fast_op;
        op_done && dif.cmd == fast_status_read_cmd;
    endsequence

    sequence seq_latch_set_frame;
        s.fsm == st_pass && s.set_pend && !cs_n_s ##1 cs_rise;
    endsequence

    a_reserved_ignored: assert property (
        op_done && rx_byte == OP_RESERVED |=> s.fsm == st_ignore && !cmd_valid_o)
        else $error("reserved opcode not ignored");

    a_ignore_hiz: assert property (
        s.fsm == st_ignore && !cs_n_s |=> so_oe_n_o)
        else $error("output driven while ignoring");

    a_fast_dummy_wait: assert property (
        seq_fast_op |=> s.fsm == st_dummy && so_oe_n_o)
        else $error("fast status read skipped dummy byte");

    a_latch_set_commit: assert property (
        seq_latch_set_frame |=> status_o[ST_LATCH_BIT])
        else $error("latch not set after set command");

    a_unused_zero: assert property (
        status_o[5:4] == 2'h0)
        else $error("unused status bits nonzero");

    a_lock_sticky: assert property (
        status_o[ST_LOCK_BIT] |=> status_o[ST_LOCK_BIT])
        else $error("serial lock cleared");

    a_busy_follow: assert property (
        nv_busy_i |=> status_o[ST_BUSY_BIT])
        else $error("busy bit missed running cycle");

    a_write_keeps_latch: assert property (
        s.fsm == st_status_write && !cs_n_s |=> $stable(status_o[ST_LATCH_BIT]))
        else $error("status write touched latch");

    a_mode_capture: assert property (
        cs_fall |=> spi_mode3_o == $past(sck_s))
        else $error("spi mode not captured");

    a_latch_needed: assert property (
        op_done && dif.needs_latch && !s.latch |=> !cmd_valid_o ##1 !cmd_valid_o)
        else $error("write-type command ran without latch");
endmodule
`default_nettype wire

// file: dv/snc_spi_master.sv
// SPI bus master model: mode 0 or 3 frames with an 80 ns serial clock.
// Assumes the device takes si on rising and drives so on falling edges.
`timescale 1ns/100ps
`default_nettype none
module snc_spi_master (
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_n_i
);
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // Undriven so reads as inverted so no stale value can pass
    task automatic xbyte(input logic m3, input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            if (m3) sck_o = 1'b0;
            si_o = b[i];
            #40 sck_o = 1'b1;
            #20 r[i] = (so_oe_n_i === 1'b0) ? so_i : ~so_i;
            #20 if (!m3) sck_o = 1'b0;
        end
    endtask
    // 12.5 MHz stays below the normal read limit
    task automatic frame(input logic m3, input logic [7:0] op, input logic [7:0] d,
                         input int n, output logic [7:0] r);
        logic [7:0] t;
        sck_o = m3;
        #40 cs_n_o = 1'b0;
        #40 xbyte(m3, op, t);
        r = 8'h00;
        for (int k = 0; k < n; k++) xbyte(m3, d, r);
        #40 cs_n_o = 1'b1;
        si_o = ~si_o;
        #60;
    endtask
endmodule
`default_nettype wire

// file: dv/spi_nvram_command_status_tb.sv
// Self-checking bench for snc_top driven by the SPI master model.
// Assumes snc_pkg opcode constants and the hand-over timing.
`timescale 1ns/100ps
`default_nettype none
module spi_nvram_command_status_tb
    import snc_pkg::*;
;
    logic clk_i = 1'b0, resetn_i = 1'b0, wp_n_i = 1'b1, hb_n = 1'b1, nvb = 1'b0;
    wire cs_n, sck, si, so_o, so_oe_n_o, cmd_valid_o, spi_mode3_o, wp_pin_gate_o;
    snc_cmd_type cmd_o, last_cmd;
    wire [7:0] status_o;
    logic [7:0] rx, d;
    logic [31:0] seed = 32'h0000_cee9;
    logic m3, oe_seen, pin_en = 1'b0, lock = 1'b0, latch = 1'b0;
    logic [1:0] level = 2'h0;
    int pulses = 0, mismatches = 0, comparisons = 0;
    logic [7:0] ops [18] = '{OP_STATUS_READ, OP_FAST_STATUS_READ, OP_STATUS_WRITE,
        OP_LATCH_SET, OP_LATCH_CLEAR, OP_ARRAY_READ, OP_FAST_ARRAY_READ, OP_ARRAY_WRITE,
        OP_NV_SAVE, OP_NV_RESTORE, OP_AUTOSAVE_EN, OP_AUTOSAVE_DIS, OP_SLEEP,
        OP_SERIAL_WRITE, OP_SERIAL_READ, OP_FAST_SERIAL_READ, OP_IDENT_READ,
        OP_FAST_IDENT_READ};
    snc_cmd_type cls [18] = '{status_read_cmd, fast_status_read_cmd, status_write_cmd,
        write_latch_set_cmd, write_latch_clear_cmd, array_read_cmd, fast_array_read_cmd,
        array_write_cmd, nv_save_cmd, nv_restore_cmd, autosave_enable_cmd,
        autosave_disable_cmd, sleep_cmd, serial_id_write_cmd, serial_id_read_cmd,
        fast_serial_id_read_cmd, ident_read_cmd, fast_ident_read_cmd};
    logic [17:0] wr = 18'h0_2f84;
    always #5 clk_i = ~clk_i;
    snc_top i_snc_top (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .wp_n_i(wp_n_i), .hw_save_busy_n_i(hb_n), .nv_busy_i(nvb), .so_o(so_o),
        .so_oe_n_o(so_oe_n_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o),
        .status_o(status_o), .spi_mode3_o(spi_mode3_o), .wp_pin_gate_o(wp_pin_gate_o));
    snc_spi_master i_snc_spi_master (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_o),
        .so_oe_n_i(so_oe_n_o));
    always @(posedge clk_i) begin
        if (cmd_valid_o === 1'b1) begin
            pulses++;
            last_cmd = cmd_o;
        end
        if (so_oe_n_o === 1'b0) oe_seen = 1'b1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] est();
        return {pin_en, lock, 2'b00, level, latch, nvb | ~hb_n};
    endfunction
    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] dd, input int n, input int ok);
        int p0;
        seed = lfsr(seed);
        m3 = seed[0];
        p0 = pulses;
        oe_seen = 1'b0;
        i_snc_spi_master.frame(m3, op, dd, n, rx);
        step(2);
        cmp8("mode", {7'h0, m3}, {7'h0, spi_mode3_o});
        cmp8("pulses", 8'(ok), 8'(pulses - p0));
        if (ok == 0) cmp8("so_hiz", 8'h00, {7'h0, oe_seen});
    endtask
    task automatic sw(input logic [7:0] v); // Latch set, then a status write
        run(OP_LATCH_SET, 8'h00, 0, 1);
        run(OP_STATUS_WRITE, v, 1, 1);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        end_sim();
    end
    initial begin
        step(6);
        resetn_i = 1'b1;
        step(4);
        cmp8("status", 8'h00, status_o);
        cmp8("oe_n", 8'h01, {7'h0, so_oe_n_o});
        $display("test reset done");
        for (int i = 0; i < 18; i++) begin
            if (wr[i]) run(OP_LATCH_SET, 8'h00, 0, 1);
            latch = wr[i] ? 1'b1 : latch;
            seed = lfsr(seed);
            d = seed[7:0] & 8'hbf;
            run(ops[i], d, (i == 1) ? 2 : 1, 1);
            cmp8("cmd", {3'h0, cls[i]}, {3'h0, last_cmd});
            if (i < 2) cmp8("spi_status", est(), rx);
            if (i == 2) {pin_en, level} = {d[7], d[3:2]};
            latch = (i == 3) ? 1'b1 : (wr[i] || i == 4) ? 1'b0 : latch;
            cmp8("status", est(), status_o);
        end
        $display("test decode done");
        run(OP_RESERVED, 8'h00, 1, 0);
        for (int k = 0; k < 4; k++) begin
            do seed = lfsr(seed); while (seed[7:0] inside {ops});
            run(seed[7:0], 8'h00, 1, 0);
        end
        run(OP_ARRAY_WRITE, 8'h00, 1, 0);
        run(OP_STATUS_WRITE, 8'hff, 1, 0);
        run(OP_LATCH_SET, OP_LATCH_CLEAR, 1, 1);
        latch = 1'b1;
        cmp8("status", est(), status_o);
        $display("test refuse done");
        run(OP_STATUS_WRITE, 8'hff, 1, 1);
        {pin_en, lock, level, latch} = 5'h1e;
        cmp8("status", est(), status_o);
        sw(8'h00);
        {pin_en, level, latch} = 4'h0;
        cmp8("status", est(), status_o);
        run(OP_LATCH_SET, 8'h00, 0, 1);
        run(OP_SERIAL_WRITE, 8'h00, 1, 0);
        run(OP_LATCH_CLEAR, 8'h00, 0, 1);
        cmp8("status", est(), status_o);
        $display("test lock done");
        sw(8'h80);
        pin_en = 1'b1;
        wp_n_i = 1'b0;
        step(5);
        cmp8("gate", 8'h01, {7'h0, wp_pin_gate_o});
        sw(8'h0c);
        latch = 1'b1;
        cmp8("status", est(), status_o);
        wp_n_i = 1'b1;
        run(OP_STATUS_WRITE, 8'h00, 1, 1);
        {pin_en, latch} = 2'h0;
        wp_n_i = 1'b0;
        sw(8'h04);
        level = 2'h1;
        cmp8("gate", 8'h00, {7'h0, wp_pin_gate_o});
        cmp8("status", est(), status_o);
        $display("test protect done");
        for (int k = 0; k < 2; k++) begin
            {nvb, hb_n} = k ? 2'b00 : 2'b11;
            step(5);
            cmp8("status", est(), status_o);
            run(OP_STATUS_READ, 8'h00, 1, 1);
            cmp8("spi_status", est(), rx);
        end
        {nvb, hb_n} = 2'b01;
        $display("test busy done");
        end_sim();
    end
endmodule
`default_nettype wire
